// ===== shared/etg_pkg.sv
// Constants, types and register map for the region trace and counting gate
package etg_pkg;
    // Bus geometry
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    // Branch record stack geometry
    localparam int DEPTH = 8;
    localparam int TOS_W = 3;
    localparam int IP_W = 64;
    localparam logic [TOS_W-1:0] TOS_ONE = 3'h1;
    localparam logic [TOS_W-1:0] TOS_RST = 3'h0;
    // Register byte addresses
    localparam logic [ADR_W-1:0] A_CTRL = 8'h00;
    localparam logic [ADR_W-1:0] A_FILTER = 8'h04;
    localparam logic [ADR_W-1:0] A_PERF_LO = 8'h08;
    localparam logic [ADR_W-1:0] A_PERF_HI = 8'h0c;
    localparam logic [ADR_W-1:0] A_TOS = 8'h10;
    localparam logic [ADR_W-1:0] A_SEL = 8'h14;
    localparam logic [ADR_W-1:0] A_SRC_LO = 8'h18;
    localparam logic [ADR_W-1:0] A_SRC_HI = 8'h1c;
    localparam logic [ADR_W-1:0] A_DST_LO = 8'h20;
    localparam logic [ADR_W-1:0] A_DST_HI = 8'h24;
    localparam logic [ADR_W-1:0] A_INFO = 8'h28;
    localparam logic [ADR_W-1:0] A_STATE = 8'h2c;
    // Field positions
    localparam int B_STEP_EN = 0;
    localparam int B_LOG_EN = 1;
    localparam int B_FAR_FILT = 8;
    localparam int B_GUARD64 = 60;
    localparam int B_GUARD_HI = B_GUARD64 - DAT_W;
    localparam int B_PRED = 63;
    localparam int B_SEL_GUARD = 3;
    localparam int B_SEL_FILT = 1;
    localparam int B_SEL_LOW = 0;
    // Interruption type reported for a breakpoint inside the region
    localparam logic [2:0] BP_TYPE_HW = 3'h3;
    localparam logic [DAT_W-1:0] ZERO_W = 32'h0;
    // Event operations from the core
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_ENTER = 3'h1,
        OP_RESUME = 3'h2,
        OP_EXIT = 3'h3,
        OP_AEX = 3'h4,
        OP_BRANCH = 3'h5,
        OP_BREAK = 3'h6
    } etg_op_e;
    // Region tracking, Gray along idle -> in -> out
    typedef enum logic [1:0] {
        RG_IDLE = 2'h0,
        RG_IN = 2'h1,
        RG_OUT = 2'h3
    } etg_rg_e;
    // One retired event from the core
    typedef struct packed {
        etg_op_e op;
        logic opt_out;
        logic far;
        logic cause_push;
        logic [IP_W-1:0] ip;
        logic [IP_W-1:0] dst;
        logic [IP_W-1:0] ssa_ip;
        logic [IP_W-1:0] async_exit_target;
        logic [IP_W-1:0] cause_dst;
    } etg_ev_s;
    // One branch record slot
    typedef struct packed {
        logic [IP_W-1:0] src;
        logic [IP_W-1:0] dst;
        logic lock_elision;
        logic restricted_transaction;
    } etg_rec_s;
endpackage

// ===== src/etg_gate.sv
// Region entry/exit trace, branch log and counter gating with Wishbone registers
//
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Branch single-step on: trap after opt-in entry by the enter operation.
// [RULE2] Branch single-step on: trap after every region exit operation.
// [RULE3] No step trap for resume entries or asynchronous exits.
// [RULE4] Opt-in entry with logging pushes enter/resume address to its destination.
// [RULE5] Exit after opt-in entry pushes exit address to exit destination.
// [RULE6] Async exit after opt-in pushes saved pointer to async exit target.
// [RULE7] After opt-in entry every branch inside the region is logged.
// [RULE8] Opt-out entry suppresses logging, pushes nothing; any exit lifts it.
// [RULE9] Opt-out with logging at entry: exit pushes entry address to exit destination.
// [RULE10] Opt-out async exit first pushes entry address to async exit target.
// [RULE11] A record pushed by the causing event then starts at async exit target.
// [RULE12] Records from region operations have source bit 63 set as predicted.
// [RULE13] Region records are never flagged lock elision or restricted transaction.
// [RULE14] Region operations are far branches, kept only if filter bit 8 clear.
// [RULE15] Global state bit 60 shows counters may be affected by protection.
// [RULE16] Opt-in entry keeps all counting unchanged and leaves bit 60 clear.
// [RULE17] Opt-out entry stops fixed counter zero and general counters; cycles go on.
// [RULE18] Opt-out entry suppresses precise sampling and sets bit 60.
// [RULE19] During opt-out region, sibling all-thread counters count own thread only.
// [RULE20] Exit or async exit resumes monitoring and restores sibling all-thread counting.
// [RULE21] Breakpoint instruction in region gives breakpoint fault of interruption type 3; the code gives UD_FAULT in an opt-out region.
// [RULE22] Hypervisor rebuilding injection from vector 3 uses type 3, not 6.
// [RULE23] Debugger keeps the saved pointer at the breakpoint instruction unchanged.
// [RULE24] Record stack is circular; top index advances per push, oldest overwritten.
module etg_gate
    import etg_pkg::*;
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic SYS_RST,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [etg_pkg::ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [etg_pkg::DAT_W-1:0] WB_DAT_I,
    output logic [etg_pkg::DAT_W-1:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Retired events from the core
    input wire etg_pkg::etg_ev_s EV,
    // Debug exceptions
    output logic STEP_TRAP,
    output logic BP_FAULT,
    output logic [2:0] BP_INT_TYPE,
    output logic UD_FAULT,
    // Counting gates
    output logic FIXED0_EN,
    output logic GP_EN,
    output logic CYCLE_EN,
    output logic PRECISE_EN,
    output logic SIB_OWN_ONLY,
    output logic GUARD_FLAG
);
    // Whole state of the block
    typedef struct packed {
        etg_rg_e region;
        logic log_at_entry;
        logic [IP_W-1:0] entry_ip;
        logic step_en;
        logic log_en;
        logic far_filt;
        logic guard;
        logic [TOS_W-1:0] tos;
        logic [TOS_W-1:0] sel;
        etg_rec_s [DEPTH-1:0] slots;
        logic ack;
        logic [DAT_W-1:0] rdat;
        logic step_trap;
        logic bp_fault;
        logic ud_fault;
        logic cnt_en;
        logic sib_own;
    } etg_st_s;

    etg_st_s st_reg;
    etg_st_s st_next;

    // Builds a record; region records get the predicted mark
    function automatic etg_rec_s mk_rec(input logic [IP_W-1:0] src,
                                       input logic [IP_W-1:0] dst,
                                       input logic region_op);
        etg_rec_s r;
        r.src = src;
        r.dst = dst;
        if (region_op)
        begin
            r.src[B_PRED] = 1'b1; // [RULE12]
        end
        r.lock_elision = 1'b0; // [RULE13]
        r.restricted_transaction = 1'b0; // [RULE13]
        return r;
    endfunction

    // Next state: bus, events, record pushes, gates
    always_comb
    begin
        logic bus_go;
        logic keep_far;
        logic p0;
        logic p1;
        etg_rec_s r0;
        etg_rec_s r1;
        logic [TOS_W-1:0] t;
        etg_rec_s cur;
        bus_go = 1'b0;
        keep_far = 1'b0;
        p0 = 1'b0;
        p1 = 1'b0;
        r0 = '0;
        r1 = '0;
        t = TOS_RST;
        cur = '0;
        st_next = st_reg;
        st_next.step_trap = 1'b0;
        st_next.bp_fault = 1'b0;
        st_next.ud_fault = 1'b0;
        bus_go = WB_CYC_I && WB_STB_I && !st_reg.ack;
        st_next.ack = bus_go;
        cur = st_reg.slots[st_reg.sel];
        // Register read and write decode
        st_next.rdat = ZERO_W;
        if (WB_ADR_I == A_CTRL)
        begin
            st_next.rdat[B_STEP_EN] = st_reg.step_en;
            st_next.rdat[B_LOG_EN] = st_reg.log_en;
            if (bus_go && WB_WE_I && WB_SEL_I[B_SEL_LOW])
            begin
                st_next.step_en = WB_DAT_I[B_STEP_EN];
                st_next.log_en = WB_DAT_I[B_LOG_EN];
            end
        end
        else if (WB_ADR_I == A_FILTER)
        begin
            st_next.rdat[B_FAR_FILT] = st_reg.far_filt;
            if (bus_go && WB_WE_I && WB_SEL_I[B_SEL_FILT])
            begin
                st_next.far_filt = WB_DAT_I[B_FAR_FILT];
            end
        end
        else if (WB_ADR_I == A_PERF_HI)
        begin
            st_next.rdat[B_GUARD_HI] = st_reg.guard; // [RULE15]
            if (bus_go && WB_WE_I && WB_SEL_I[B_SEL_GUARD] && WB_DAT_I[B_GUARD_HI])
            begin
                st_next.guard = 1'b0;
            end
        end
        else if (WB_ADR_I == A_TOS)
        begin
            st_next.rdat[TOS_W-1:0] = st_reg.tos;
        end
        else if (WB_ADR_I == A_SEL)
        begin
            st_next.rdat[TOS_W-1:0] = st_reg.sel;
            if (bus_go && WB_WE_I && WB_SEL_I[B_SEL_LOW])
            begin
                st_next.sel = WB_DAT_I[TOS_W-1:0];
            end
        end
        else if (WB_ADR_I == A_SRC_LO)
        begin
            st_next.rdat = cur.src[DAT_W-1:0];
        end
        else if (WB_ADR_I == A_SRC_HI)
        begin
            st_next.rdat = cur.src[IP_W-1:DAT_W];
        end
        else if (WB_ADR_I == A_DST_LO)
        begin
            st_next.rdat = cur.dst[DAT_W-1:0];
        end
        else if (WB_ADR_I == A_DST_HI)
        begin
            st_next.rdat = cur.dst[IP_W-1:DAT_W];
        end
        else if (WB_ADR_I == A_INFO)
        begin
            st_next.rdat[1:0] = {cur.restricted_transaction, cur.lock_elision};
        end
        else if (WB_ADR_I == A_STATE)
        begin
            st_next.rdat[1:0] = st_reg.region;
            st_next.rdat[2] = st_reg.log_at_entry;
        end
        // Region operations are far branches
        keep_far = !st_reg.far_filt; // [RULE14]
        // Core events
        case (EV.op)
            OP_ENTER, OP_RESUME:
            begin
                if (st_reg.region == RG_IDLE)
                begin
                    if (!EV.opt_out)
                    begin
                        st_next.region = RG_IN;
                        // Resume never traps
                        st_next.step_trap = st_reg.step_en && (EV.op == OP_ENTER); // [RULE1] [RULE3]
                        p0 = st_reg.log_en && keep_far; // [RULE4]
                        r0 = mk_rec(EV.ip, EV.dst, 1'b1);
                    end
                    else
                    begin
                        // Nothing pushed; entry address kept for the exit record
                        st_next.region = RG_OUT; // [RULE8]
                        st_next.entry_ip = EV.ip;
                        st_next.log_at_entry = st_reg.log_en;
                        st_next.guard = 1'b1; // [RULE18]
                    end
                end
            end
            OP_EXIT:
            begin
                if (st_reg.region != RG_IDLE)
                begin
                    st_next.step_trap = st_reg.step_en; // [RULE2]
                    if (st_reg.region == RG_IN)
                    begin
                        p0 = st_reg.log_en && keep_far; // [RULE5]
                        r0 = mk_rec(EV.ip, EV.dst, 1'b1);
                    end
                    else
                    begin
                        p0 = st_reg.log_at_entry && keep_far; // [RULE9]
                        r0 = mk_rec(st_reg.entry_ip, EV.dst, 1'b1);
                    end
                    st_next.region = RG_IDLE; // [RULE8] [RULE20]
                end
            end
            OP_AEX:
            begin
                if (st_reg.region != RG_IDLE)
                begin
                    // No step trap on asynchronous exit
                    if (st_reg.region == RG_IN)
                    begin
                        p0 = st_reg.log_en && keep_far; // [RULE6]
                        r0 = mk_rec(EV.ssa_ip, EV.async_exit_target, 1'b1);
                    end
                    else
                    begin
                        p0 = st_reg.log_at_entry && keep_far; // [RULE10]
                        r0 = mk_rec(st_reg.entry_ip, EV.async_exit_target, 1'b1);
                    end
                    // Causing event record follows, starting at the exit target
                    p1 = st_reg.log_en && EV.cause_push; // [RULE11]
                    r1 = mk_rec(EV.async_exit_target, EV.cause_dst, 1'b1);
                    st_next.region = RG_IDLE; // [RULE20]
                end
            end
            OP_BRANCH:
            begin
                // Suppressed inside an opt-out region
                p0 = st_reg.log_en && (st_reg.region != RG_OUT)
                     && !(EV.far && st_reg.far_filt); // [RULE7] [RULE8]
                r0 = mk_rec(EV.ip, EV.dst, 1'b0);
            end
            OP_BREAK:
            begin
                st_next.bp_fault = (st_reg.region == RG_IN); // [RULE21]
                st_next.ud_fault = (st_reg.region == RG_OUT);
            end
            default:
            begin
                p0 = 1'b0;
            end
        endcase
        // Circular pushes, up to two per cycle in order
        t = st_reg.tos;
        if (p0)
        begin
            t = t + TOS_ONE; // [RULE24]
            st_next.slots[t] = r0;
        end
        if (p1)
        begin
            t = t + TOS_ONE; // [RULE24]
            st_next.slots[t] = r1;
        end
        st_next.tos = t;
        // Counting gates follow the region state
        st_next.cnt_en = (st_next.region != RG_OUT); // [RULE16] [RULE17] [RULE20]
        st_next.sib_own = (st_next.region == RG_OUT); // [RULE19] [RULE20]
    end

    // State register
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            st_reg <= '0;
            st_reg.region <= RG_IDLE;
            st_reg.tos <= TOS_RST;
            st_reg.cnt_en <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flops, except the constants BP_INT_TYPE and CYCLE_EN
    assign WB_DAT_O = st_reg.rdat;
    assign WB_ACK_O = st_reg.ack;
    assign STEP_TRAP = st_reg.step_trap;
    assign BP_FAULT = st_reg.bp_fault;
    assign BP_INT_TYPE = BP_TYPE_HW; // [RULE21]
    assign UD_FAULT = st_reg.ud_fault;
    assign FIXED0_EN = st_reg.cnt_en; // [RULE17]
    assign GP_EN = st_reg.cnt_en; // [RULE17]
    assign CYCLE_EN = 1'b1; // [RULE17]
    assign PRECISE_EN = st_reg.cnt_en; // [RULE18]
    assign SIB_OWN_ONLY = st_reg.sib_own; // [RULE19]
    assign GUARD_FLAG = st_reg.guard; // [RULE15]

    // Checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    logic rg_idle;
    logic rg_in;
    logic rg_out;
    assign rg_idle = (st_reg.region == RG_IDLE);
    assign rg_in = (st_reg.region == RG_IN);
    assign rg_out = (st_reg.region == RG_OUT);

    step_enter_a: assert property ( // [RULE1]
        (EV.op == OP_ENTER) && !EV.opt_out && rg_idle && st_reg.step_en |=> STEP_TRAP)
        else $error("no step trap after opt-in enter");
    step_exit_a: assert property ( // [RULE2]
        (EV.op == OP_EXIT) && !rg_idle && st_reg.step_en |=> STEP_TRAP)
        else $error("no step trap after exit");
    no_step_a: assert property ( // [RULE3]
        (EV.op == OP_RESUME) || (EV.op == OP_AEX) |=> !STEP_TRAP)
        else $error("step trap on resume or async exit");
    optout_quiet_a: assert property ( // [RULE8]
        (EV.op == OP_ENTER) && EV.opt_out && rg_idle |=> $stable(st_reg.tos))
        else $error("opt-out entry pushed a record");
    optout_exit_a: assert property ( // [RULE9]
        (EV.op == OP_EXIT) && rg_out && st_reg.log_at_entry && !st_reg.far_filt
        |=> (st_reg.tos == $past(st_reg.tos) + TOS_ONE)
            && (st_reg.slots[st_reg.tos].src[IP_W-2:0] == $past(st_reg.entry_ip[IP_W-2:0])))
        else $error("opt-out exit record wrong");
    aex_pair_a: assert property ( // [RULE11]
        (EV.op == OP_AEX) && rg_out && st_reg.log_at_entry && st_reg.log_en
        && !st_reg.far_filt && EV.cause_push
        |=> st_reg.tos == $past(st_reg.tos) + TOS_ONE + TOS_ONE)
        else $error("async exit did not push two records");
    pred_bit_a: assert property ( // [RULE12]
        (EV.op == OP_EXIT) && rg_in && st_reg.log_en && !st_reg.far_filt
        |=> st_reg.slots[st_reg.tos].src[B_PRED])
        else $error("region record not marked predicted");
    far_filter_a: assert property ( // [RULE14]
        (EV.op inside {OP_ENTER, OP_RESUME, OP_EXIT}) && st_reg.far_filt
        |=> $stable(st_reg.tos))
        else $error("filtered far record pushed");
    guard_set_a: assert property ( // [RULE18]
        (EV.op == OP_ENTER) && EV.opt_out && rg_idle |=> GUARD_FLAG && !PRECISE_EN)
        else $error("opt-out entry did not set guard");
    gates_a: assert property ( // [RULE17]
        rg_out |-> !FIXED0_EN && !GP_EN && CYCLE_EN && SIB_OWN_ONLY)
        else $error("counting not gated in opt-out region");
    resume_a: assert property ( // [RULE20]
        ((EV.op == OP_EXIT) || (EV.op == OP_AEX)) && rg_out
        |=> FIXED0_EN && PRECISE_EN && !SIB_OWN_ONLY)
        else $error("monitoring not restored on exit");
    bp_a: assert property ( // [RULE21]
        (EV.op == OP_BREAK) && rg_in |=> BP_FAULT && (BP_INT_TYPE == BP_TYPE_HW))
        else $error("breakpoint fault missing in region");
    ack_a: assert property (
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held two cycles");

    optin_cycle_c: cover property (
        (EV.op == OP_ENTER) && !EV.opt_out && rg_idle ##[1:20] (EV.op == OP_EXIT));
    optout_aex_c: cover property (
        rg_out && (EV.op == OP_AEX) && EV.cause_push);
    wrap_c: cover property (
        (st_reg.tos == TOS_RST) ##1 (st_reg.tos != TOS_RST) ##[1:40] (st_reg.tos == TOS_RST));
    bp_c: cover property (BP_FAULT);
endmodule

// ===== test/etg_dbg_model.sv
// Debugger and hypervisor model that services breakpoint faults from the region
`timescale 1ns/1ps
module etg_dbg_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fault from the block and the pointer saved on the way out
    input wire logic bp_fault,
    input wire logic [63:0] ssa_ip,
    // Pointer kept for the next entry and rebuilt event type
    output logic [63:0] resume_ip,
    output logic [2:0] inj_type
);
    // Handler keeps the saved pointer and rebuilds the type from vector 3
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            resume_ip <= 64'h0;
            inj_type <= 3'h0;
        end
        else if (bp_fault)
        begin
            resume_ip <= ssa_ip;
            inj_type <= 3'h3;
        end
    end
endmodule

// ===== test/etg_gate_test.sv
// Self-checking bench for the region trace and counting gate
`timescale 1ns/1ps
module etg_gate_test;
    import etg_pkg::*;
    localparam logic [63:0] p63 = 64'h8000000000000000;
    // Clock, reset, bus and event drive
    logic MCLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h0;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    etg_ev_s ev = '0;
    // Outputs of the block and the model
    logic st, bp, ud, f0, gp, cy, pr, sib, grd;
    logic [2:0] bpt;
    logic [2:0] inj;
    logic [63:0] rip;
    // Bench state
    int error_cnt = 0;
    int cmp_count = 0;
    logic [31:0] rd;
    logic [63:0] s_src, s_dst;
    logic [2:0] t = 3'h0;
    logic pst, pbp, pud;

    etg_gate dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .EV(ev), .STEP_TRAP(st), .BP_FAULT(bp), .BP_INT_TYPE(bpt),
        .UD_FAULT(ud), .FIXED0_EN(f0), .GP_EN(gp), .CYCLE_EN(cy), .PRECISE_EN(pr),
        .SIB_OWN_ONLY(sib), .GUARD_FLAG(grd));
    etg_dbg_model partner (.clk(MCLK), .rst(SYS_RST), .bp_fault(bp), .ssa_ip(ev.ip),
        .resume_ip(rip), .inj_type(inj));

    // Clock
    always #50 MCLK = ~MCLK;

    // Verdict and end of run
    task automatic report_and_stop;
        if (error_cnt == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Compare one value
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Classic single Wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge MCLK);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (n = 0; n < 20 && ack !== 1'b1; n++)
            @(posedge MCLK);
        if (ack !== 1'b1)
        begin
            error_cnt++;
            $display("[ERR] %0t bus timeout", $time);
            report_and_stop();
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // One core event, pulses sampled in the answer cycle
    task automatic evt(input etg_op_e op, input logic oo, input logic [63:0] ip,
        input logic [63:0] dst);
        @(posedge MCLK);
        ev.op <= op;
        ev.opt_out <= oo;
        ev.ip <= ip;
        ev.dst <= dst;
        @(posedge MCLK);
        ev.op <= OP_NONE;
        #1;
        pst = st;
        pbp = bp;
        pud = ud;
    endtask

    // Gate levels packed as f0 gp cy pr sib grd
    function automatic logic [63:0] gv();
        return {58'h0, f0, gp, cy, pr, sib, grd};
    endfunction

    // Top index equals the expected index t
    task automatic chk_tos;
        wb(1'b0, A_TOS, 32'h0);
        chk({61'h0, rd[2:0]}, {61'h0, t});
    endtask

    // Read one slot back and compare both addresses
    task automatic chk_slot(input logic [2:0] idx, input logic [63:0] src,
        input logic [63:0] dst);
        wb(1'b1, A_SEL, {29'h0, idx});
        wb(1'b0, A_SRC_LO, 32'h0);
        s_src[31:0] = rd;
        wb(1'b0, A_SRC_HI, 32'h0);
        s_src[63:32] = rd;
        wb(1'b0, A_DST_LO, 32'h0);
        s_dst[31:0] = rd;
        wb(1'b0, A_DST_HI, 32'h0);
        s_dst[63:32] = rd;
        chk(s_src, src);
        chk(s_dst, dst);
    endtask

    // Expect one new record at the next index
    task automatic chk_rec(input logic [63:0] src, input logic [63:0] dst);
        t = t + 3'h1;
        chk_tos();
        chk_slot(t, src, dst);
    endtask

    // Reset levels and an unmapped read
    task automatic t_reset;
        chk(gv(), 64'h3c);
        chk({61'h0, bpt}, 64'h3);
        chk_tos();
        wb(1'b0, 8'h30, 32'h0);
        chk({32'h0, rd}, 64'h0);
    endtask

    // Opt-in entry, inner branch and exit with stepping and logging
    task automatic t_optin;
        wb(1'b1, A_CTRL, 32'h3);
        evt(OP_ENTER, 1'b0, 64'h1000, 64'h2000);
        chk({63'h0, pst}, 64'h1);
        chk(gv(), 64'h3c);
        chk_rec(64'h1000 | p63, 64'h2000);
        evt(OP_BRANCH, 1'b0, 64'h2100, 64'h2200);
        chk_rec(64'h2100, 64'h2200);
        evt(OP_EXIT, 1'b0, 64'h2300, 64'h1004);
        chk({63'h0, pst}, 64'h1);
        chk_rec(64'h2300 | p63, 64'h1004);
        wb(1'b0, A_INFO, 32'h0);
        chk({32'h0, rd}, 64'h0);
    endtask

    // Resume entry and asynchronous exit give no step trap
    task automatic t_resume;
        evt(OP_RESUME, 1'b0, 64'h1100, 64'h2000);
        chk({63'h0, pst}, 64'h0);
        chk_rec(64'h1100 | p63, 64'h2000);
        evt(OP_AEX, 1'b0, 64'h2400, 64'h0);
        chk({63'h0, pst}, 64'h0);
        chk_rec(64'h5000 | p63, 64'h6000);
    endtask

    // Opt-out entry, suppressed branch, exit, guard clear
    task automatic t_optout;
        evt(OP_ENTER, 1'b1, 64'h1200, 64'h2000);
        chk_tos();
        chk(gv(), 64'h0b);
        wb(1'b0, A_STATE, 32'h0);
        chk({32'h0, rd}, 64'h7);
        evt(OP_BRANCH, 1'b0, 64'h2100, 64'h2200);
        chk_tos();
        evt(OP_EXIT, 1'b0, 64'h2300, 64'h1204);
        chk({63'h0, pst}, 64'h1);
        chk(gv(), 64'h3d);
        chk_rec(64'h1200 | p63, 64'h1204);
        wb(1'b0, A_PERF_HI, 32'h0);
        chk({63'h0, rd[28]}, 64'h1);
        wb(1'b1, A_PERF_HI, 32'h10000000);
        wb(1'b0, A_PERF_HI, 32'h0);
        chk({63'h0, rd[28]}, 64'h0);
        chk(gv(), 64'h3c);
    endtask

    // Opt-out resume left by an asynchronous exit that pushes its own record
    task automatic t_aex_out;
        @(posedge MCLK);
        ev.cause_push <= 1'b1;
        evt(OP_RESUME, 1'b1, 64'h1300, 64'h2000);
        chk({63'h0, pst}, 64'h0);
        evt(OP_AEX, 1'b0, 64'h2500, 64'h0);
        chk(gv(), 64'h3d);
        @(posedge MCLK);
        ev.cause_push <= 1'b0;
        // Two records land in one cycle, entry record first
        t = t + 3'h2;
        chk_tos();
        chk_slot(t - 3'h1, 64'h1300 | p63, 64'h6000);
        chk_slot(t, 64'h6000 | p63, 64'h7000);
    endtask

    // Breakpoint in opt-in and opt-out regions
    task automatic t_break;
        evt(OP_ENTER, 1'b0, 64'h1400, 64'h2000);
        chk_rec(64'h1400 | p63, 64'h2000);
        evt(OP_BREAK, 1'b0, 64'h2600, 64'h0);
        chk({63'h0, pbp}, 64'h1);
        @(posedge MCLK);
        #1;
        chk(rip, 64'h2600);
        chk({61'h0, inj}, 64'h3);
        evt(OP_EXIT, 1'b0, 64'h2700, 64'h1404);
        chk_rec(64'h2700 | p63, 64'h1404);
        evt(OP_ENTER, 1'b1, 64'h1500, 64'h2000);
        evt(OP_BREAK, 1'b0, 64'h2600, 64'h0);
        chk({62'h0, pbp, pud}, 64'h1);
        evt(OP_EXIT, 1'b0, 64'h2700, 64'h1504);
        chk_rec(64'h1500 | p63, 64'h1504);
    endtask

    // Far filter drops region records; stack wraps after eight pushes
    task automatic t_filter_wrap;
        int i;
        wb(1'b1, A_FILTER, 32'h100);
        evt(OP_ENTER, 1'b0, 64'h1600, 64'h2000);
        evt(OP_EXIT, 1'b0, 64'h2300, 64'h1604);
        chk_tos();
        wb(1'b1, A_FILTER, 32'h0);
        for (i = 0; i < 8; i++)
            evt(OP_BRANCH, 1'b0, 64'h9000 + 64'(i), 64'h9100);
        t = t + 3'h7;
        chk_rec(64'h9007, 64'h9100);
    endtask

    // Main sequence
    initial
    begin
        ev.ssa_ip = 64'h5000;
        ev.async_exit_target = 64'h6000;
        ev.cause_dst = 64'h7000;
        ev.far = 1'b1;
        repeat (10) @(posedge MCLK);
        SYS_RST <= 1'b0;
        t_reset();
        t_optin();
        t_resume();
        t_optout();
        t_aex_out();
        t_break();
        t_filter_wrap();
        report_and_stop();
    end
endmodule
